// [rtl/wsc_map.vh]
/*
 Constants of the wiper serial command unit: command codes, field
 positions, widths and reset values. Assumes inclusion by bare name.
*/
`ifndef WSC_MAP_VH
`define WSC_MAP_VH
`define WSC_FRAME_BITS 24
`define WSC_WIPER_BITS 10
`define WSC_CMD_MSB 23
`define WSC_CMD_LSB 20
`define WSC_ADR_MSB 19
`define WSC_ADR_LSB 16
`define WSC_DAT_MSB 15
`define WSC_CMD_NOP 4'h0
`define WSC_CMD_RESTORE 4'h1
`define WSC_CMD_STORE 4'h2
`define WSC_CMD_SPARE_STORE 4'h3
`define WSC_CMD_RESET 4'h8
`define WSC_CMD_SPARE_READ 4'h9
`define WSC_CMD_WIPER_READ 4'hA
`define WSC_CMD_WRITE 4'hB
`define WSC_CMD_SHIFT_LEFT 4'hC
`define WSC_CMD_INCREMENT 4'hE
`define WSC_SPARE_FIRST 4'h2
`define WSC_SPARE_WORDS 16
`define WSC_WIPER_RESET 10'h200
`define WSC_WIPER_FULL 10'h3FF
`define WSC_BIT_RESET 5'h00
`define WSC_BIT_LAST 5'h17
`endif

// [rtl/wsc_unit.v]
/*
 Serial command decoder of a 1024-position digital potentiometer with
 a wiper register, a nonvolatile wiper copy and spare nonvolatile words.
 Assumes serial pins from outside the ref_clk_i domain; they are
 synchronised and the serial clock edges are found by sampling.
 Data is taken on rising serial clock edges and changed on falling.
*/
`timescale 1ns/1ps
`include "wsc_map.vh"

module wsc_unit (
   // Clock and reset
   input wire ref_clk_i,
   input wire rstn_i,
   // Serial port
   input wire sclk_i,
   input wire csn_i,
   input wire sdi_i,
   output reg sdo_o,
   // Protection and preset pins
   input wire write_protect_n_i,
   input wire preset_recall_pin_n_i,
   // Wiper state
   output wire [9:0] wiper_setting_o,
   output wire read_power_mode_o
);

   reg [2:0] sclk_s1_q, sclk_s2_q;
   reg [2:0] csn_s1_q, csn_s2_q;
   reg [2:0] sdi_s1_q, sdi_s2_q;
   reg [2:0] pr_s1_q, pr_s2_q;
   reg sclk_old_q, csn_old_q, pr_old_q;
   reg [23:0] shift_q;
   reg [23:0] out_q;
   reg [4:0] bits_q;
   reg [9:0] wiper_setting_register_q;
   reg [9:0] nv_wiper_q;
   reg [15:0] nonvolatile_store_q [0:15];
   reg read_mode_q;
   reg boot_q;
   reg [23:0] word;
   reg [3:0] cmd, adr;
   reg [23:0] next_out;
   reg write_protect_n_s, wp_s1_q;
   integer k;

   wire sclk_s = sclk_s2_q[0];
   wire csn_s = csn_s2_q[0];
   wire sdi_s = sdi_s2_q[0];
   wire pr_s = pr_s2_q[0];
   wire rise = sclk_s & ~sclk_old_q & ~csn_s;
   wire fall = ~sclk_s & sclk_old_q & ~csn_s;
   wire frame_end = csn_s & ~csn_old_q;
   wire nv_ok = write_protect_n_s;

   assign wiper_setting_o = wiper_setting_register_q;
   assign read_power_mode_o = read_mode_q;

   function [9:0] wsc_sat_add;
      input [10:0] v;
      begin
         wsc_sat_add = v[10] ? `WSC_WIPER_FULL : v[9:0];
      end
   endfunction

   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sclk_s1_q <= 3'h0;
         sclk_s2_q <= 3'h0;
         csn_s1_q <= 3'h7;
         csn_s2_q <= 3'h7;
         sdi_s1_q <= 3'h0;
         sdi_s2_q <= 3'h0;
         pr_s1_q <= 3'h7;
         pr_s2_q <= 3'h7;
         wp_s1_q <= 1'b0;
         write_protect_n_s <= 1'b0;
         sclk_old_q <= 1'b0;
         csn_old_q <= 1'b1;
         pr_old_q <= 1'b1;
      end else begin
         sclk_s1_q <= {2'h0, sclk_i};
         sclk_s2_q <= sclk_s1_q;
         csn_s1_q <= {2'h0, csn_i};
         csn_s2_q <= csn_s1_q;
         sdi_s1_q <= {2'h0, sdi_i};
         sdi_s2_q <= sdi_s1_q;
         pr_s1_q <= {2'h0, preset_recall_pin_n_i};
         pr_s2_q <= pr_s1_q;
         wp_s1_q <= write_protect_n_i;
         write_protect_n_s <= wp_s1_q;
         sclk_old_q <= sclk_s;
         csn_old_q <= csn_s;
         pr_old_q <= pr_s;
      end
   end

   always @* begin
      word = shift_q;
      cmd = shift_q[`WSC_CMD_MSB:`WSC_CMD_LSB];
      adr = shift_q[`WSC_ADR_MSB:`WSC_ADR_LSB];
      next_out = shift_q;
      if (cmd == `WSC_CMD_SPARE_READ) begin
         next_out = {shift_q[23:16], nonvolatile_store_q[adr]};
      end else if (cmd == `WSC_CMD_WIPER_READ) begin
         next_out = {shift_q[23:16], 6'h00, wiper_setting_register_q};
      end
   end

   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         shift_q <= 24'h000000;
         out_q <= 24'h000000;
         bits_q <= `WSC_BIT_RESET;
         sdo_o <= 1'b0;
         wiper_setting_register_q <= `WSC_WIPER_RESET;
         nv_wiper_q <= `WSC_WIPER_RESET;
         read_mode_q <= 1'b0;
         boot_q <= 1'b1;
         for (k = 0; k < `WSC_SPARE_WORDS; k = k + 1) begin
            nonvolatile_store_q[k] <= 16'h0000;
         end
      end else begin
         boot_q <= 1'b0;
         if (boot_q) begin
            wiper_setting_register_q <= nv_wiper_q;
         end
         if (pr_old_q & ~pr_s) begin
            wiper_setting_register_q <= nv_wiper_q;
         end
         if (csn_s) begin
            bits_q <= `WSC_BIT_RESET;
         end
         if (fall) begin
            sdo_o <= out_q[23];
            out_q <= {out_q[22:0], 1'b0};
         end
         if (rise) begin
            shift_q <= {shift_q[22:0], sdi_s};
            if (bits_q != `WSC_BIT_LAST + 5'h02) begin
               bits_q <= bits_q + 5'h01;
            end
         end
         if (~csn_s & csn_old_q) begin
            sdo_o <= out_q[23];
            out_q <= {out_q[22:0], 1'b0};
         end
         if (frame_end && bits_q == `WSC_BIT_LAST + 5'h01) begin
            out_q <= next_out;
            case (cmd)
               `WSC_CMD_NOP: begin
                  read_mode_q <= 1'b0;
               end
               `WSC_CMD_RESTORE: begin
                  wiper_setting_register_q <= nv_wiper_q;
                  read_mode_q <= 1'b1;
               end
               `WSC_CMD_STORE: begin
                  if (nv_ok) begin
                     nv_wiper_q <= wiper_setting_register_q;
                  end
               end
               `WSC_CMD_SPARE_STORE: begin
                  if (nv_ok) begin
                     nonvolatile_store_q[adr] <= word[15:0];
                  end
               end
               `WSC_CMD_WRITE: begin
                  wiper_setting_register_q <= word[9:0];
               end
               `WSC_CMD_INCREMENT: begin
                  wiper_setting_register_q <=
                     wsc_sat_add({1'b0, wiper_setting_register_q} +
                     11'h001);
               end
               `WSC_CMD_SHIFT_LEFT: begin
                  wiper_setting_register_q <=
                     wsc_sat_add({wiper_setting_register_q, 1'b0});
               end
               default: begin
                  if (cmd[3:2] == 2'b10 && cmd[1:0] == 2'b00) begin
                     wiper_setting_register_q <= nv_wiper_q;
                  end
               end
            endcase
         end
      end
   end

endmodule

// [sim/wsc_unit_asserts.sv]
/* Port checker of the serial command unit.
 Assumes it is bound onto wsc_unit. */
`timescale 1ns/1ps
module wsc_unit_asserts (
   input wire ref_clk_i, rstn_i, sclk_i, csn_i, sdi_i, sdo_o,
   input wire write_protect_n_i, preset_recall_pin_n_i,
   input wire [9:0] wiper_setting_o,
   input wire read_power_mode_o
);
   wire pr = preset_recall_pin_n_i;
   wire [9:0] w = wiper_setting_o;
   wire m = read_power_mode_o;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   a_wiper_frame: assert property ((!csn_i && pr)[*8] |=> $stable(w))
      else $error("wiper moved in frame");
   a_wiper_idle: assert property ((csn_i && pr)[*8] |=> $stable(w))
      else $error("wiper moved while idle");
   a_mode_frame: assert property ((!csn_i)[*8] |=> $stable(m))
      else $error("power mode moved in frame");
   a_mode_idle: assert property (csn_i[*8] |=> $stable(m))
      else $error("power mode moved while idle");
   a_mode_rise: assert property ($rose(m) |-> csn_i)
      else $error("power mode rose in frame");
   a_sdo_high: assert property ((!csn_i && sclk_i)[*4] |=> $stable(sdo_o))
      else $error("output bit moved at high clock");
   a_sdo_idle: assert property (csn_i[*8] |=> $stable(sdo_o))
      else $error("output bit moved while idle");
   a_reset_value: assert property ($rose(rstn_i) |-> w == 10'h200 && !m)
      else $error("wrong state after reset");
   c_mode: cover property ($rose(m));
   c_full: cover property (w == 10'h3FF);
   c_preset: cover property ($fell(pr));
endmodule
bind wsc_unit wsc_unit_asserts wsc_unit_asserts_i (.ref_clk_i, .rstn_i,
   .sclk_i, .csn_i, .sdi_i, .sdo_o, .write_protect_n_i,
   .preset_recall_pin_n_i, .wiper_setting_o, .read_power_mode_o);

// [sim/wsc_host.sv]
/* Host model of the serial port.
 Assumes it is called at falling edges of an 8 ns bench clock. */
`timescale 1ns/1ps
module wsc_host (
   // Serial port
   output logic sclk_o = 1'b0,
   output logic csn_o = 1'b1,
   output logic sdi_o = 1'b0,
   input wire sdo_i
);
   // Sends n bits MSB first at a 64 ns clock and returns what came back.
   task automatic xfer(input logic [23:0] w, input int n,
      output logic [23:0] r);
      r = 24'h000000;
      csn_o = 1'b0;
      for (int i = 23; i > 23 - n; i--) begin
         sdi_o = w[i];
         #32 sclk_o = 1'b1;
         #32 r[i] = sdo_i;
         sclk_o = 1'b0;
      end
      sdi_o = ~sdi_o;
      #32 csn_o = 1'b1;
      #200;
   endtask
endmodule

// [sim/wsc_unit_tb_top.sv]
/* Self-checking bench of the serial command unit.
 Assumes the host model and the bound checker. */
`timescale 1ns/1ps
module wsc_unit_tb_top;
   logic clk = 0, rstn = 0, wp_n = 1, pr_n = 1;
   wire sclk, csn, sdi, sdo, mode;
   wire [9:0] wiper;
   int failures = 0, comparisons = 0;
   logic [23:0] r;
   always #4 clk = ~clk;
   wsc_host wsc_host_i (.sclk_o(sclk), .csn_o(csn), .sdi_o(sdi), .sdo_i(sdo));
   wsc_unit wsc_unit_i (.ref_clk_i(clk), .rstn_i(rstn), .sclk_i(sclk),
      .csn_i(csn), .sdi_i(sdi), .sdo_o(sdo), .write_protect_n_i(wp_n),
      .preset_recall_pin_n_i(pr_n), .wiper_setting_o(wiper),
      .read_power_mode_o(mode));
   task chk(input logic [23:0] s, e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task c(input logic [23:0] w, e, input logic [9:0] v);
      wsc_host_i.xfer(w, 24, r);
      chk(r, e);
      chk({14'h0000, wiper}, {14'h0000, v});
   endtask
   task t_step;
      c(24'hB00100, 24'h000000, 10'h100);
      c(24'hE00000, 24'hB00100, 10'h101);
      c(24'hE00000, 24'hE00000, 10'h102);
      c(24'h200000, 24'hE00000, 10'h102);
      c(24'hB00000, 24'h200000, 10'h000);
      c(24'h100000, 24'hB00000, 10'h102);
      chk({23'h000000, mode}, 24'h000001);
      c(24'h000000, 24'h100000, 10'h102);
      chk({23'h000000, mode}, 24'h000000);
      c(24'hB00000, 24'h000000, 10'h000);
      c(24'h800000, 24'hB00000, 10'h102);
   endtask
   task t_shift;
      c(24'hB00200, 24'h800000, 10'h200);
      c(24'hC00000, 24'hB00200, 10'h3FF);
      c(24'hA00000, 24'hC00000, 10'h3FF);
      c(24'h000000, 24'hA003FF, 10'h3FF);
   endtask
   task t_spare;
      c(24'h32AAAA, 24'h000000, 10'h3FF);
      c(24'h335555, 24'h32AAAA, 10'h3FF);
      c(24'h920000, 24'h335555, 10'h3FF);
      c(24'h930000, 24'h92AAAA, 10'h3FF);
      c(24'h000000, 24'h935555, 10'h3FF);
   endtask
   task t_wp;
      wp_n = 1'b0;
      c(24'hB00050, 24'h000000, 10'h050);
      c(24'h200000, 24'hB00050, 10'h050);
      c(24'h321234, 24'h200000, 10'h050);
      c(24'h100000, 24'h321234, 10'h102);
      c(24'h920000, 24'h100000, 10'h102);
      c(24'h000000, 24'h92AAAA, 10'h102);
      wp_n = 1'b1;
   endtask
   task t_pins;
      c(24'hB00000, 24'h000000, 10'h000);
      pr_n = 1'b0;
      #80 pr_n = 1'b1;
      #200 chk({14'h0000, wiper}, 24'h000102);
      wsc_host_i.xfer(24'hB00111, 23, r);
      chk({14'h0000, wiper}, 24'h000102);
   endtask
   task test_done;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge clk);
      rstn = 1'b1;
      repeat (8) @(negedge clk);
      chk({14'h0000, wiper}, 24'h000200);
      wsc_host_i.xfer(24'h000000, 24, r);
      t_step;
      t_shift;
      t_spare;
      t_wp;
      t_pins;
      test_done;
   end
   initial begin
      #500000 failures++;
      test_done;
   end
endmodule
